// ===== hw/calseq_pkg.sv
// package for the calibration sequencer: register map, layouts, timing
package calseq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [7:0] PHASE_S = 8'h28;
  localparam logic [7:0] START_HOLD_S = 8'h02;
  localparam logic [7:0] RETRIG_HOLD_S = 8'h01;
  localparam logic [7:0] PURGE_RST = 8'h0A;
  localparam logic [7:0] DAMP_RST = 8'h00;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIME = 8'h04;
  localparam logic [7:0] REG_ZMAP = 8'h08;
  localparam logic [7:0] REG_SMAP = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_CHAN = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;

  // ctrl field positions
  localparam int CTRL_VALVES = 0;
  localparam int CTRL_DI_EN = 1;
  localparam int CTRL_PUMP_MENU = 2;
  localparam int CTRL_PUMP_DI = 3;
  localparam int CTRL_SAMPLE_DI = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // cmd bits (write pulses)
  localparam int CMD_CANCEL = 0;
  localparam int CMD_ZALL = 1;
  localparam int CMD_SALL = 2;
  localparam int CMD_ZSALL = 3;
  localparam int CMD_ZONE = 4;
  localparam int CMD_SONE = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_PREPURGE = 3'b001,
    CS_CAL = 3'b010,
    CS_PICK = 3'b011,
    CS_POSTPURGE = 3'b100
  } calseq_state_t;

  typedef enum logic [1:0] {
    PR_NONE = 2'b00,
    PR_ZERO = 2'b01,
    PR_SPAN = 2'b10,
    PR_ZS = 2'b11
  } calseq_proc_t;

  // status word seen by software
  typedef struct packed {
    logic [7:0] remain;
    logic [3:0] gas_valve;
    logic sample_flow;
    logic spanning;
    logic zeroing;
    logic purging;
    logic done;
    logic busy;
  } calseq_stat_t;

  // digital input bundle
  typedef struct packed {
    logic cancel;
    logic zero_every_channel;
    logic span_every_channel;
    logic zero_then_span_every_channel;
    logic pump;
    logic sample;
    logic [7:0] valve;
  } calseq_din_t;

endpackage : calseq_pkg

// ===== hw/calseq_top.sv
// calibration sequencer with wishbone register file and valve/pump drive
`timescale 1ns/1ps

module calseq_top
  import calseq_pkg::*;
#(
  parameter int NCH = 4,
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // digital input pins
  input wire calseq_din_t din_i,
  // valve and pump drive
  output logic [7:0] valve_o,
  output logic sample_valve_o,
  output logic pump_o,
  // status
  output logic [NCH-1:0] cal_chan_o,
  output logic zeroing_o,
  output logic spanning_o,
  output logic done_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // two channel masks share one bus byte, so four channels is the ceiling
  if (NCH < 1 || NCH > 4) $error("NCH must be 1..4");
  if (TICK_DIV < 2) $error("TICK_DIV must be at least 2");

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest valve index whose channel mask overlaps the pending set
  function automatic logic [3:0] pick_valve(input logic [7:0][NCH-1:0] map, input logic [NCH-1:0] pend);
    logic [3:0] r;
    r = 4'hF;
    for (int i = 7; i >= 0; i--)
      if ((map[i] & pend) != '0) r = 4'(i);
    return r;
  endfunction : pick_valve

  function automatic logic [NCH-1:0] all_chan(input logic [7:0][NCH-1:0] map);
    logic [NCH-1:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r = r | map[i];
    return r;
  endfunction : all_chan

  // pack a valve map into the bus layout, one valve pair per byte
  function automatic logic [31:0] map_word(input logic [7:0][NCH-1:0] map);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < 8; i++) w[8*(i/2)+NCH*(i%2)+:NCH] = map[i];
    return w;
  endfunction : map_word

  // ----------------------------------------------------------------
  // registers and signals
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [7:0] purge_r, damp_r;
  logic [7:0][NCH-1:0] zmap_r, smap_r;
  logic [5:0] cmd_pulse;
  calseq_din_t s1_r, s2_r, prev_r;
  logic [$clog2(TICK_DIV)-1:0] div_r;
  logic tick;
  calseq_state_t st_r;
  calseq_proc_t proc_r;
  logic span_r;
  logic [7:0] cnt_r;
  logic [3:0] gv_r;
  logic [NCH-1:0] zpend_r, spend_r;
  logic done_r;
  logic [2:0] req_r;
  logic [7:0] hold_r;
  logic [7:0] valve_in;
  logic sample_ok;
  logic [7:0][NCH-1:0] cur_map;
  logic [NCH-1:0] cur_pend;
  logic [3:0] next_v;
  logic wb_hit;
  calseq_stat_t stat;

  logic wb_wr;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge where the master samples ack high
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // ----------------------------------------------------------------
  // wishbone slave, one wait state, ack one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_hit;
  end

  // write side; sel bytes honored on config words, taken with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= CTRL_RST;
      purge_r <= PURGE_RST;
      damp_r <= DAMP_RST;
      zmap_r <= '0;
      smap_r <= '0;
    end
    else if (wb_wr)
    begin
      unique case (wb_adr_i)
        REG_CTRL: if (wb_sel_i[0]) ctrl_r[7:0] <= wb_dat_i[7:0];
        REG_TIME:
        begin
          if (wb_sel_i[0]) purge_r <= wb_dat_i[7:0];
          if (wb_sel_i[1]) damp_r <= wb_dat_i[15:8];
        end
        REG_ZMAP: for (int i = 0; i < 4; i++) if (wb_sel_i[i]) zmap_r[2*i+:2] <= (2*NCH)'(wb_dat_i[8*i+:2*NCH]);
        REG_SMAP: for (int i = 0; i < 4; i++) if (wb_sel_i[i]) smap_r[2*i+:2] <= (2*NCH)'(wb_dat_i[8*i+:2*NCH]);
        default: ;
      endcase
    end
  end

  // command strobes are single-cycle pulses on the acked write
  assign cmd_pulse = (wb_wr && wb_adr_i == REG_CMD && wb_sel_i[0]) ? wb_dat_i[5:0] : 6'h00;

  // read data, unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_hit && !wb_we_i)
    begin
      unique case (wb_adr_i)
        REG_CTRL: wb_dat_o <= ctrl_r;
        REG_TIME: wb_dat_o <= {16'h0000, damp_r, purge_r};
        REG_ZMAP: wb_dat_o <= map_word(zmap_r);
        REG_SMAP: wb_dat_o <= map_word(smap_r);
        REG_STAT: wb_dat_o <= 32'(stat);
        REG_CHAN: wb_dat_o <= {8'h00, 8'(spend_r), 8'(zpend_r), 8'(cal_chan_o)};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers; stage two and the edge-detect stage after it are read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      s1_r <= din_i;
      s2_r <= s1_r;
      prev_r <= s2_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || div_r == ($clog2(TICK_DIV))'(TICK_DIV - 1))
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end
  assign tick = (div_r == ($clog2(TICK_DIV))'(TICK_DIV - 1));

  // ----------------------------------------------------------------
  // remote start capture: latch first edge, confirm by hold time
  // ----------------------------------------------------------------
  // first rising edge wins; later ones ignored while latched
  // start fires after held long enough once idle
  // no input start without valves fitted
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_r <= 3'b000;
      hold_r <= 8'h00;
    end
    else if (!ctrl_r[CTRL_DI_EN] || !ctrl_r[CTRL_VALVES])
    begin
      req_r <= 3'b000;
      hold_r <= 8'h00;
    end
    else if (req_r == 3'b000)
    begin
      hold_r <= 8'h00;
      if (s2_r.zero_every_channel && !prev_r.zero_every_channel) req_r <= 3'b001;
      else if (s2_r.span_every_channel && !prev_r.span_every_channel) req_r <= 3'b010;
      else if (s2_r.zero_then_span_every_channel && !prev_r.zero_then_span_every_channel) req_r <= 3'b100;
    end
    else if ((req_r & {s2_r.zero_then_span_every_channel, s2_r.span_every_channel,
                       s2_r.zero_every_channel}) == 3'b000)
      req_r <= 3'b000;  // released too early: drop it
    else if (st_r == CS_IDLE && tick)
    begin
      hold_r <= hold_r + 1'b1;
      if (hold_r + 1'b1 >= (done_r ? RETRIG_HOLD_S : START_HOLD_S))
        req_r <= 3'b000;  // consumed by the sequencer this cycle
    end
  end

  logic go;
  calseq_proc_t go_proc;
  logic cancel;
  always_comb
  begin
    go = 1'b0;
    go_proc = PR_NONE;
    if (st_r == CS_IDLE && tick && req_r != 3'b000 &&
        (req_r & {s2_r.zero_then_span_every_channel, s2_r.span_every_channel, s2_r.zero_every_channel}) != 3'b000 &&
        hold_r + 1'b1 >= (done_r ? RETRIG_HOLD_S : START_HOLD_S))
    begin
      go = 1'b1;
      go_proc = req_r[0] ? PR_ZERO : (req_r[1] ? PR_SPAN : PR_ZS);
    end
    else if (st_r == CS_IDLE && ctrl_r[CTRL_VALVES])
    begin
      if (cmd_pulse[CMD_ZSALL]) begin go = 1'b1; go_proc = PR_ZS; end
      else if (cmd_pulse[CMD_ZALL] || cmd_pulse[CMD_ZONE]) begin go = 1'b1; go_proc = PR_ZERO; end
      else if (cmd_pulse[CMD_SALL] || cmd_pulse[CMD_SONE]) begin go = 1'b1; go_proc = PR_SPAN; end
    end
  end
  assign cancel = st_r != CS_IDLE && (cmd_pulse[CMD_CANCEL] ||
                  (ctrl_r[CTRL_DI_EN] && s2_r.cancel && !prev_r.cancel));

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign cur_map = span_r ? smap_r : zmap_r;
  assign cur_pend = span_r ? spend_r : zpend_r;
  assign next_v = pick_valve(cur_map, cur_pend);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= CS_IDLE;
      proc_r <= PR_NONE;
      span_r <= 1'b0;
      cnt_r <= 8'h00;
      gv_r <= 4'hF;
      zpend_r <= '0;
      spend_r <= '0;
      done_r <= 1'b0;
    end
    // cancel beats every state; the gas valve is dropped at once and idle drive from the valve pins takes over
    else if (cancel)
    begin
      st_r <= CS_IDLE;
      gv_r <= 4'hF;
      proc_r <= PR_NONE;
    end
    else
    begin
      unique case (st_r)
        CS_IDLE:
          if (go)
          begin
            proc_r <= go_proc;
            span_r <= go_proc == PR_SPAN;
            zpend_r <= go_proc == PR_SPAN ? '0 : all_chan(zmap_r);
            spend_r <= go_proc == PR_ZERO ? '0 : all_chan(smap_r);
            done_r <= 1'b0;
            st_r <= CS_PICK;
          end
        // choose next valve with pending channels
        CS_PICK:
          if (next_v != 4'hF)
          begin
            gv_r <= next_v;
            cnt_r <= purge_r;
            st_r <= CS_PREPURGE;
          end
          // zeros done, span follows for zero-then-span
          else if (!span_r && proc_r == PR_ZS)
            span_r <= 1'b1;
          else
          begin
            gv_r <= 4'hF;
            cnt_r <= 8'(purge_r + {damp_r, 1'b0});
            st_r <= CS_POSTPURGE;
          end
        CS_PREPURGE:
          if (cnt_r == 8'h00)
          begin
            cnt_r <= PHASE_S;
            st_r <= CS_CAL;
          end
          else if (tick)
            cnt_r <= cnt_r - 1'b1;
        CS_CAL:
          if (cnt_r == 8'h00)
          begin
            if (span_r) spend_r <= spend_r & ~smap_r[gv_r[2:0]];
            else zpend_r <= zpend_r & ~zmap_r[gv_r[2:0]];
            st_r <= CS_PICK;
          end
          else if (tick)
            cnt_r <= cnt_r - 1'b1;
        // done only at zero with sample flow
        CS_POSTPURGE:
          if (cnt_r == 8'h00 && sample_valve_o)
          begin
            done_r <= 1'b1;
            proc_r <= PR_NONE;
            st_r <= CS_IDLE;
          end
          else if (tick && cnt_r != 8'h00)
            cnt_r <= cnt_r - 1'b1;
        default: st_r <= CS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // valve, pump and status drive
  // ----------------------------------------------------------------
  // level valve inputs, valve one highest
  always_comb
  begin
    valve_in = 8'h00;
    for (int i = 7; i >= 0; i--)
      if (s2_r.valve[i]) valve_in = 8'(1) << i;
    if (!ctrl_r[CTRL_DI_EN]) valve_in = 8'h00;
  end

  logic [7:0] valve_nxt;
  logic running;
  assign running = st_r == CS_PREPURGE || st_r == CS_CAL;
  assign valve_nxt = (st_r != CS_IDLE) ? (running ? 8'(1) << gv_r[2:0] : 8'h00) : valve_in;
  // sample when nothing else open and enabled; inputs outrank it
  assign sample_ok = valve_nxt == 8'h00 && (st_r != CS_IDLE || !ctrl_r[CTRL_SAMPLE_DI] || s2_r.sample);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valve_o <= 8'h00;
      sample_valve_o <= 1'b0;
      pump_o <= 1'b0;
    end
    else
    begin
      valve_o <= valve_nxt;
      sample_valve_o <= sample_ok;
      // pump source, forced off with all closed
      pump_o <= (valve_nxt != 8'h00 || sample_ok) &&
                (ctrl_r[CTRL_PUMP_DI] ? s2_r.pump : ctrl_r[CTRL_PUMP_MENU]);
    end
  end

  // phase name and channels under calibration
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cal_chan_o <= '0;
      zeroing_o <= 1'b0;
      spanning_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      cal_chan_o <= (st_r == CS_CAL) ? cur_map[gv_r[2:0]] & cur_pend : '0;
      zeroing_o <= st_r == CS_CAL && !span_r;
      spanning_o <= st_r == CS_CAL && span_r;
      done_o <= done_r;
    end
  end

  assign stat = '{remain: cnt_r, gas_valve: gv_r, sample_flow: sample_valve_o,
                  spanning: spanning_o, zeroing: zeroing_o,
                  purging: st_r == CS_PREPURGE || st_r == CS_POSTPURGE,
                  done: done_r, busy: st_r != CS_IDLE};

endmodule : calseq_top

// ===== verif/calseq_chk.sv
// port checker for the calibration sequencer
`timescale 1ns/1ps
module calseq_chk
  import calseq_pkg::*;
#(
  parameter int NCH = 4,
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // drive and status
  input wire logic [7:0] valve_o,
  input wire logic sample_valve_o,
  input wire logic pump_o,
  input wire logic [NCH-1:0] cal_chan_o,
  input wire logic zeroing_o,
  input wire logic spanning_o,
  input wire logic done_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic phase;
  int unsigned ph_cnt_r;
  assign phase = zeroing_o || spanning_o;
  // phase length; a cancel may only shorten it
  always_ff @(posedge clk_i)
    if (rst_i || !phase)
      ph_cnt_r <= 0;
    else
      ph_cnt_r <= ph_cnt_r + 1;
  // bus answers one cycle after a fresh request
  a_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_unmapped_zero: assert property ((wb_ack_o && !wb_we_i && wb_adr_i > 8'h18) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_valve_onehot: assert property ($onehot0(valve_o))
    else $error("several gas valves");
  a_sample_alone: assert property (sample_valve_o |-> valve_o == 8'h00)
    else $error("sample with gas valve");
  // pump stops dry, registered lag allowed
  a_pump_dry: assert property ((valve_o == 8'h00 && !sample_valve_o) [*3] |-> !pump_o)
    else $error("pump on with valves shut");
  a_phase_excl: assert property (!(zeroing_o && spanning_o))
    else $error("zero and span together");
  a_phase_chans: assert property (phase |-> cal_chan_o != '0)
    else $error("phase without channels");
  a_gas_applied: assert property (phase |-> (valve_o != 8'h00 && !sample_valve_o))
    else $error("phase without gas");
  a_valve_hold: assert property ((phase && $past(phase)) |-> $stable(valve_o))
    else $error("valve moved in phase");
  a_phase_bound: assert property (phase |-> ph_cnt_r < 41 * TICK_DIV)
    else $error("phase too long");
  a_done_sample: assert property ($rose(done_o) |-> (sample_valve_o && valve_o == 8'h00))
    else $error("done without sample");
  c_zero: cover property ($rose(zeroing_o));
  c_span: cover property ($rose(spanning_o));
  c_done: cover property ($rose(done_o));
endmodule : calseq_chk

bind calseq_top calseq_chk #(.NCH(NCH), .TICK_DIV(TICK_DIV)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .valve_o(valve_o),
  .sample_valve_o(sample_valve_o), .pump_o(pump_o), .cal_chan_o(cal_chan_o),
  .zeroing_o(zeroing_o), .spanning_o(spanning_o), .done_o(done_o));

// ===== verif/calseq_remote.sv
// remote controller model driving the digital input pins
`timescale 1ns/1ps
module calseq_remote
  import calseq_pkg::*;
#(
  parameter int unsigned TICK_DIV = 20
)
(
  // clock
  input wire logic clk_i,
  // pins towards the sequencer
  output calseq_din_t din_o
);
  int unsigned held[14];
  initial din_o = '0;
  // cycles each pin has stood high
  always @(posedge clk_i)
    for (int i = 0; i < 14; i++)
      held[i] <= din_o[i] ? held[i] + 1 : 0;
  // pins change just after an edge
  task automatic drive(input int idx, input logic v);
    @(posedge clk_i);
    din_o[idx] <= v;
  endtask : drive
  task automatic release_pin(input int idx);
    while (held[idx] < (START_HOLD_S + 1) * TICK_DIV)
      @(posedge clk_i);
    din_o[idx] <= 1'b0;
  endtask : release_pin
endmodule : calseq_remote

// ===== verif/tb_top.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
`define WAITC(c) \
  n = 0; \
  while (!(c) && n < 4000) \
  begin \
    @(posedge clk_i); \
    n++; \
  end \
  `CHK("wait bound", 1'b1, n < 4000)
module tb_top
  import calseq_pkg::*;
;
  localparam int T = 20;
  localparam int NC = 4;
  logic clk_i;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [3:0] sel = 4'hF;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic [7:0] valve_o;
  logic sample_valve_o;
  logic pump_o;
  logic [NC-1:0] cal_chan_o;
  logic zeroing_o;
  logic spanning_o;
  logic done_o;
  calseq_din_t din;
  int n;
  int num_errors = 0;
  int total_checks = 0;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  calseq_remote #(.TICK_DIV(T)) rem (.clk_i(clk_i), .din_o(din));
  calseq_top #(.NCH(NC), .TICK_DIV(T)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .din_i(din), .valve_o(valve_o), .sample_valve_o(sample_valve_o),
    .pump_o(pump_o), .cal_chan_o(cal_chan_o), .zeroing_o(zeroing_o), .spanning_o(spanning_o),
    .done_o(done_o));
  // one classic cycle; request held until ack is sampled
  task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= sel;
    wb_adr_i <= a;
    wb_dat_i <= d;
    `WAITC(wb_ack_o === 1'b1)
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_cycle
  // one valve step: prepurge then a forty tick phase
  task step(input logic [7:0] v, input logic [NC-1:0] ch, input logic sp);
    `WAITC(valve_o === v)
    `WAITC(zeroing_o === 1'b1 || spanning_o === 1'b1)
    `CHK("prepurge time", 1'b1, n >= 9 * T && n <= 11 * T)
    `CHK("gas valve", v, valve_o)
    `CHK("span phase", sp, spanning_o)
    `CHK("zero phase", !sp, zeroing_o)
    `CHK("channels", ch, cal_chan_o)
    `WAITC(valve_o !== v)
    `CHK("phase time", 1'b1, n >= 39 * T && n <= 41 * T)
  endtask : step
  task t_reset;
    wb_cycle(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl reset", CTRL_RST, rd)
    wb_cycle(1'b0, REG_TIME, 32'h0);
    `CHK("time reset", {16'h0000, DAMP_RST, PURGE_RST}, rd)
    wb_cycle(1'b0, 8'hFC, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("idle sample", 1'b1, sample_valve_o)
    `CHK("idle pump", 1'b0, pump_o)
    $display("test reset done");
  endtask : t_reset
  // zero valves one and three, span valve two, damping two
  task t_seq;
    wb_cycle(1'b1, REG_ZMAP, 32'h0000_0C03);
    wb_cycle(1'b1, REG_SMAP, 32'h0000_00F0);
    wb_cycle(1'b1, REG_TIME, 32'h0000_020A);
    // low byte only: damping must survive
    sel = 4'h1;
    wb_cycle(1'b1, REG_TIME, 32'h0000_FF0A);
    sel = 4'hF;
    wb_cycle(1'b0, REG_TIME, 32'h0);
    `CHK("damping kept", 32'h0000_020A, rd)
    wb_cycle(1'b1, REG_CMD, 32'h0000_0001 << CMD_ZSALL);
    step(8'h01, 4'h3, 1'b0);
    step(8'h04, 4'hC, 1'b0);
    step(8'h02, 4'hF, 1'b1);
    `WAITC(valve_o === 8'h00)
    @(posedge clk_i);
    `CHK("sample open", 1'b1, sample_valve_o)
    `WAITC(done_o === 1'b1)
    `CHK("postpurge time", 1'b1, n >= 13 * T && n <= 15 * T)
    `CHK("done on sample", 1'b1, sample_valve_o)
    wb_cycle(1'b0, REG_STAT, 32'h0);
    `CHK("status done", 32'h0000_03E2, rd)
    $display("test sequence done");
  endtask : t_seq
  // valve, sample and pump pins as levels
  task t_levels;
    wb_cycle(1'b1, REG_CTRL, 32'h0000_001F);
    rem.drive(1, 1'b1);
    rem.drive(3, 1'b1);
    repeat (4) @(posedge clk_i);
    `CHK("valve order", 8'h02, valve_o)
    `CHK("sample shut", 1'b0, sample_valve_o)
    `CHK("pump pin low", 1'b0, pump_o)
    rem.drive(9, 1'b1);
    repeat (4) @(posedge clk_i);
    `CHK("pump pin high", 1'b1, pump_o)
    rem.drive(1, 1'b0);
    rem.drive(3, 1'b0);
    repeat (4) @(posedge clk_i);
    `CHK("sample pin low", 1'b0, sample_valve_o)
    `CHK("pump dry", 1'b0, pump_o)
    rem.drive(8, 1'b1);
    rem.drive(7, 1'b1);
    rem.drive(12, 1'b1);
    rem.release_pin(12);
    `WAITC(valve_o === 8'h01)
    `CHK("run overrides pin", 8'h01, valve_o)
    wb_cycle(1'b1, REG_CMD, 32'h0000_0001);
    rem.drive(7, 1'b0);
    rem.drive(8, 1'b0);
    rem.drive(9, 1'b0);
    $display("test levels done");
  endtask : t_levels
  // edge pins: idle cancel, cancel, first wins, no valves
  task t_pins;
    wb_cycle(1'b1, REG_CTRL, 32'h0000_0003);
    rem.drive(13, 1'b1);
    rem.release_pin(13);
    rem.drive(12, 1'b1);
    rem.release_pin(12);
    `WAITC(valve_o !== 8'h00)
    `CHK("start after cancel", 8'h01, valve_o)
    rem.drive(13, 1'b1);
    `WAITC(valve_o === 8'h00)
    `CHK("cancel stops", 1'b0, zeroing_o)
    rem.release_pin(13);
    rem.drive(11, 1'b1);
    repeat (T) @(posedge clk_i);
    rem.drive(12, 1'b1);
    rem.release_pin(11);
    rem.release_pin(12);
    `WAITC(valve_o !== 8'h00)
    `CHK("first pin wins", 8'h02, valve_o)
    // trigger during a run, still held after the run ends
    rem.drive(12, 1'b1);
    repeat (T) @(posedge clk_i);
    wb_cycle(1'b1, REG_CMD, 32'h0000_0001);
    `WAITC(valve_o === 8'h01)
    `CHK("held past end", 8'h01, valve_o)
    // trigger during a run, released before the run ends
    rem.drive(12, 1'b0);
    rem.drive(11, 1'b1);
    repeat (T) @(posedge clk_i);
    rem.drive(11, 1'b0);
    wb_cycle(1'b1, REG_CMD, 32'h0000_0001);
    repeat (5 * T) @(posedge clk_i);
    `CHK("early release dropped", 8'h00, valve_o)
    wb_cycle(1'b1, REG_CTRL, 32'h0000_0002);
    rem.drive(12, 1'b1);
    rem.release_pin(12);
    repeat (2 * T) @(posedge clk_i);
    `CHK("no valves no start", 8'h00, valve_o)
    wb_cycle(1'b1, REG_CTRL, 32'h0000_0003);
    $display("test pins done");
  endtask : t_pins
  // bus start commands other than CMD_ZSALL, each cancelled after its phase begins
  task automatic t_bus;
    int cb[4] = '{CMD_ZALL, CMD_SALL, CMD_ZONE, CMD_SONE};
    logic [7:0] ev[4] = '{8'h01, 8'h02, 8'h01, 8'h02};
    for (int i = 0; i < 4; i++)
    begin
      wb_cycle(1'b1, REG_CMD, 32'h0000_0001 << cb[i]);
      `WAITC(zeroing_o === 1'b1 || spanning_o === 1'b1)
      `CHK("bus valve", ev[i], valve_o)
      `CHK("bus phase", ev[i][1], spanning_o)
      wb_cycle(1'b1, REG_CMD, 32'h0000_0001);
      `WAITC(valve_o === 8'h00)
    end
    $display("test bus done");
  endtask : t_bus
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_seq();
    t_levels();
    t_pins();
    t_bus();
    give_verdict();
  end
  // watchdog, about five times the expected run
  initial
  begin
    #(40 * 25000);
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
